/* File: hdl/pfs_channel.sv */
// One PWM channel with fault shutdown, compensator routing and sync.
`timescale 1ns/10ps
`default_nettype none
module pfs_channel #(
    parameter logic [1:0] CH_IDX = 2'h0
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Configuration
    input wire pfs_pkg::pfs_cfg_t i_cfg,
    // Fault pins and clear strobes
    input wire logic [pfs_pkg::FLT_W-1:0] i_fault_pin,
    input wire logic [pfs_pkg::FLT_W-1:0] i_fault_clr,
    // Compensator outputs
    input wire logic [pfs_pkg::NUM_CH-1:0][pfs_pkg::COMP_W-1:0] i_comp_val,
    // Sync inputs
    input wire logic [pfs_pkg::NUM_CH-1:0] i_master_trig,
    input wire logic i_sync_in,
    // PWM outputs
    output logic o_pwm_a,
    output logic o_pwm_b,
    output logic o_phase_trig,
    // Sync pin drive
    output logic o_sync_out,
    output logic o_sync_oe,
    // Status
    output logic o_fault_irq,
    output pfs_pkg::pfs_stat_t o_stat
);
    import pfs_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------

    // Picks the compensator index the channel follows.
    function automatic logic [SEL_W-1:0] comp_index(input pfs_mode_t mode,
                                                    input logic [SEL_W-1:0] sel);
        begin
            if (mode == PFS_MODE_RESON) begin
                comp_index = CH_IDX;
            end else begin
                comp_index = sel;
            end
        end
    endfunction

    // ----------------------------------------
    // Fault latches
    // ----------------------------------------
    logic [FLT_W-1:0] lat;
    logic [FLT_W-1:0] pin_lvl;

    // pins pass through the latch stage
    pfs_fault_latch u_latch (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_pin(i_fault_pin),
        .i_clr(i_fault_clr),
        .o_latched(lat),
        .o_pin_level(pin_lvl),
        .o_irq(o_fault_irq)
    );

    // ----------------------------------------
    // Sync sources and period counter
    // ----------------------------------------
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic sync_in_q, sync_in_d;
    logic isync_hit, rsync_hit, wrap, period_start;

    // select bits pick the master channel
    // remote sync pin edge resets the counter
    always_comb begin
        sync_in_d = i_sync_in;
        isync_hit = i_cfg.isync_en & i_master_trig[i_cfg.isync_sel];
        rsync_hit = i_cfg.rsync_en & i_sync_in & ~sync_in_q;
        wrap = (cnt_q >= i_cfg.period);
        period_start = wrap | isync_hit | rsync_hit;
        if (period_start) begin
            cnt_d = CNT_RST;
        end else begin
            cnt_d = cnt_q + 16'h0001;
        end
    end

    // Counter and sync edge registers.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= CNT_RST;
            sync_in_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            sync_in_q <= sync_in_d;
        end
    end

    // ----------------------------------------
    // Compensator routing
    // ----------------------------------------
    logic [COMP_W-1:0] duty;

    always_comb begin
        duty = i_comp_val[comp_index(i_cfg.mode, i_cfg.comp_sel)];
    end

    // ----------------------------------------
    // Fault gating and output stage
    // ----------------------------------------
    logic eff_a, eff_b;
    logic blank_a_q, blank_a_d, blank_b_q, blank_b_d;
    logic pwm_a_q, pwm_a_d, pwm_b_q, pwm_b_d, trig_q, trig_d;

    // Fault mapping onto outputs and resume at the period start.
    always_comb begin
        // other modes gate each phase alone
        if (i_cfg.mode == PFS_MODE_NORMAL) begin
            eff_a = |lat;
            eff_b = |lat;
        end else begin
            eff_a = lat[0];
            eff_b = lat[1];
        end
        eff_a = eff_a & i_cfg.fault_en;
        eff_b = eff_b & i_cfg.fault_en;
        // blanking ends only at a period start
        blank_a_d = eff_a | (blank_a_q & ~period_start);
        blank_b_d = eff_b | (blank_b_q & ~period_start);
        pwm_a_d = (cnt_d < duty) & ~blank_a_d;
        pwm_b_d = (cnt_d >= duty) & ~blank_b_d;
        trig_d = (cnt_d == i_cfg.phase);
    end

    // Output and blanking registers.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            blank_a_q <= 1'b0;
            blank_b_q <= 1'b0;
            pwm_a_q <= 1'b0;
            pwm_b_q <= 1'b0;
            trig_q <= 1'b0;
        end else begin
            blank_a_q <= blank_a_d;
            blank_b_q <= blank_b_d;
            pwm_a_q <= pwm_a_d;
            pwm_b_q <= pwm_b_d;
            trig_q <= trig_d;
        end
    end

    assign o_pwm_a = pwm_a_q;
    assign o_pwm_b = pwm_b_q;
    assign o_phase_trig = trig_q;

    // ----------------------------------------
    // Sync output
    // ----------------------------------------

    pfs_sync_div u_div (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_period_start(period_start),
        .i_ratio(i_cfg.sync_div),
        .o_pulse(o_sync_out)
    );

    // pin driven only when set as output source
    assign o_sync_oe = i_cfg.sync_out_src;

    // Status bundle for software.
    always_comb begin
        o_stat.fault_latched = lat;
        o_stat.fault_pin_level = pin_lvl;
        o_stat.blank_a = blank_a_q;
        o_stat.blank_b = blank_b_q;
        o_stat.count = cnt_q;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_fault_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.fault_en && eff_a) |=> !o_pwm_a)
        else $error("Output A active during a fault.");
    a_normal_both: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.fault_en && i_cfg.mode == PFS_MODE_NORMAL && |lat) |=> (!o_pwm_a && !o_pwm_b))
        else $error("Normal mode fault left an output active.");
    a_split_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.mode != PFS_MODE_NORMAL && !blank_a_q && !lat[0]) |-> !eff_a)
        else $error("Fault one gated output A outside normal mode.");
    a_resume_start: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $fell(blank_a_q) |-> (cnt_q == CNT_RST))
        else $error("Output A resumed mid period.");
    a_reson_comp: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.mode == PFS_MODE_RESON) |-> (duty == i_comp_val[CH_IDX]))
        else $error("Resonant mode used the wrong compensator.");
    a_master_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.isync_en && i_master_trig[i_cfg.isync_sel]) |=> (cnt_q == CNT_RST))
        else $error("Master trigger did not reset the counter.");
    a_remote_reset: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.rsync_en && i_sync_in && !sync_in_q) |=> (cnt_q == CNT_RST))
        else $error("Remote sync edge did not reset the counter.");
    a_sync_boundary: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_sync_out |-> (cnt_q == CNT_RST))
        else $error("Sync pulse off the period boundary.");

    // ----------------------------------------
    // Further checks on the outputs, fault latch, routing and counter
    // ----------------------------------------
    // Several of the checks below compare the registered outputs with the compare result that the
    // counter shown in the status bundle implies, so a broken gate cannot hide behind
    // the same expression that drives it.

    a_fault_off_b: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.fault_en && eff_b) |=> !o_pwm_b)
        else $error("Output B active during a fault.");

    a_enable_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!i_cfg.fault_en && !blank_a_q) |=> (o_pwm_a == (o_stat.count < $past(duty))))
        else $error("Output A blanked with fault enable clear.");

    // a fault pin raises the interrupt
    a_irq_raise: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (|i_fault_pin) |=> o_fault_irq)
        else $error("Fault pin did not raise the interrupt.");

    a_split_b: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.mode != PFS_MODE_NORMAL && !blank_b_q && !lat[1])
        |=> (o_pwm_b == (o_stat.count >= $past(duty))))
        else $error("Fault zero gated output B outside normal mode.");

    a_phase_b_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.fault_en && i_cfg.mode != PFS_MODE_NORMAL && lat[1]) |=> !o_pwm_b)
        else $error("Fault one left output B active.");

    // fault one leaves A free of B
    a_split_a_free: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.mode != PFS_MODE_NORMAL && !blank_a_q && !lat[0])
        |=> (o_pwm_a == (o_stat.count < $past(duty))))
        else $error("Output A did not follow its compare outside normal mode.");

    a_latch_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_fault_clr[0] && !i_fault_pin[0]) |=> !o_stat.fault_latched[0])
        else $error("Fault latch survived a clear.");

    a_blank_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (blank_a_q && !period_start) |=> blank_a_q)
        else $error("Output A blanking ended mid period.");

    // B resumes at a period start
    a_resume_b: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $fell(blank_b_q) |-> (cnt_q == CNT_RST))
        else $error("Output B resumed mid period.");

    // counter wraps at the period end
    a_wrap_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (cnt_q >= i_cfg.period) |=> (cnt_q == CNT_RST))
        else $error("Counter did not wrap at the period end.");

    a_comp_route: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_cfg.mode != PFS_MODE_RESON) |-> (duty == i_comp_val[i_cfg.comp_sel]))
        else $error("Selector did not route its compensator.");

    // phase trigger sits on its count
    a_phase_pulse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_phase_trig |-> (o_stat.count == i_cfg.phase))
        else $error("Phase trigger off its count.");

    // disabled syncs leave the counter running
    a_sync_refused: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!i_cfg.rsync_en && !i_cfg.isync_en && cnt_q < i_cfg.period)
        |=> (cnt_q == $past(cnt_q) + 16'h0001))
        else $error("Counter reset by a disabled sync source.");
endmodule
`default_nettype wire

/* File: hdl/pfs_pkg.sv */
// Shared constants and carrier types for the fault and sync control channel.
package pfs_pkg;
    // ----------------------------------------
    // Widths and counts
    // ----------------------------------------
    localparam int CNT_W = 16;
    localparam int COMP_W = 16;
    localparam int NUM_CH = 4;
    localparam int SEL_W = 2;
    localparam int DIV_W = 4;
    localparam int FLT_W = 2;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [DIV_W-1:0] DIV_RST = 4'h0;
    localparam logic [FLT_W-1:0] FLT_RST = 2'h0;

    // Channel operating modes.
    typedef enum logic [1:0] {
        PFS_MODE_NORMAL = 2'h0,
        PFS_MODE_MULTI = 2'h1,
        PFS_MODE_RESON = 2'h3,
        PFS_MODE_PHASE = 2'h2
    } pfs_mode_t;

    // Software configuration bits of the channel.
    typedef struct packed {
        logic fault_en;
        pfs_mode_t mode;
        logic [SEL_W-1:0] comp_sel;
        logic isync_en;
        logic [SEL_W-1:0] isync_sel;
        logic rsync_en;
        logic [DIV_W-1:0] sync_div;
        logic sync_out_src;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] phase;
    } pfs_cfg_t;

    // Status visible to software.
    typedef struct packed {
        logic [FLT_W-1:0] fault_latched;
        logic [FLT_W-1:0] fault_pin_level;
        logic blank_a;
        logic blank_b;
        logic [CNT_W-1:0] count;
    } pfs_stat_t;
endpackage

/* File: hdl/pfs_fault_latch.sv */
// Fault pin latches with software clear and pin level readback.
`timescale 1ns/10ps
`default_nettype none
module pfs_fault_latch (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Fault pins and clear strobes
    input wire logic [pfs_pkg::FLT_W-1:0] i_pin,
    input wire logic [pfs_pkg::FLT_W-1:0] i_clr,
    // Latched faults and readback
    output logic [pfs_pkg::FLT_W-1:0] o_latched,
    output logic [pfs_pkg::FLT_W-1:0] o_pin_level,
    output logic o_irq
);
    import pfs_pkg::*;

    logic [FLT_W-1:0] lat_q, lat_d, lvl_q, lvl_d;

    // ----------------------------------------
    // Latch update per fault bit
    // ----------------------------------------
    for (genvar g = 0; g < FLT_W; g++) begin : g_bit
        always_comb begin
            lat_d[g] = i_pin[g] | (lat_q[g] & ~i_clr[g]); // A new fault beats the clear.
        end
    end

    always_comb begin
        lvl_d = i_pin;
    end

    // Registers for latches and readback.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lat_q <= FLT_RST;
            lvl_q <= FLT_RST;
        end else begin
            lat_q <= lat_d;
            lvl_q <= lvl_d;
        end
    end

    // latched faults to channel and processor
    assign o_latched = lat_q;
    assign o_pin_level = lvl_q;
    assign o_irq = |lat_q;

    a_latch_sets: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_pin[0] |=> o_latched[0])
        else $error("Fault latch did not set.");
    a_latch_sets_b: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_pin[1] |=> o_latched[1])
        else $error("Second fault latch did not set.");
    a_latch_holds: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (o_latched[1] && !i_clr[1]) |=> o_latched[1])
        else $error("Fault latch dropped without a clear.");
    a_level_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ##1 o_pin_level == $past(i_pin))
        else $error("Pin level readback is wrong.");
endmodule
`default_nettype wire

/* File: hdl/pfs_sync_div.sv */
// Divider that emits a sync pulse every programmed ratio plus one periods.
`timescale 1ns/10ps
`default_nettype none
module pfs_sync_div (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Period boundary and ratio
    input wire logic i_period_start,
    input wire logic [pfs_pkg::DIV_W-1:0] i_ratio,
    // Sync pulse
    output logic o_pulse
);
    import pfs_pkg::*;

    logic [DIV_W-1:0] cnt_q, cnt_d;
    logic pulse_q, pulse_d;

    // one pulse per ratio plus one periods
    always_comb begin
        cnt_d = cnt_q;
        pulse_d = 1'b0;
        if (i_period_start) begin
            if (cnt_q >= i_ratio) begin
                cnt_d = DIV_RST;
                pulse_d = 1'b1; // single cycle at the boundary
            end else begin
                cnt_d = cnt_q + 4'h1;
            end
        end
    end

    // Divider registers.
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= DIV_RST;
            pulse_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign o_pulse = pulse_q;

    a_pulse_width: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_pulse |=> !o_pulse)
        else $error("Sync pulse longer than one cycle.");
    a_pulse_cause: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        o_pulse |-> $past(i_period_start))
        else $error("Sync pulse without a period boundary.");
endmodule
`default_nettype wire

/* File: dv/pfs_far_model.sv */
// Far-side model: remote sync source and sync pin receiver.
`timescale 1ns/10ps
`default_nettype none
module pfs_far_model (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Source command and channel sync pin
    input wire logic i_go,
    input wire logic i_pin_out,
    input wire logic i_pin_oe,
    // Remote sync line and received pulse count
    output logic o_sync,
    output logic [7:0] o_seen
);
    logic [1:0] hold_q;
    // A go request raises the remote line for two cycles; the pin reads low while undriven.
    // pin counts only when enabled
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hold_q <= 2'h0;
            o_seen <= 8'h00;
        end else begin
            hold_q <= i_go ? 2'h2 : ((hold_q != 2'h0) ? hold_q - 2'h1 : 2'h0);
            if (i_pin_oe && i_pin_out) begin
                o_seen <= o_seen + 8'h01;
            end
        end
    end
    // The line is high while the hold count runs.
    assign o_sync = (hold_q != 2'h0);
endmodule
`default_nettype wire

/* File: dv/test_pfs_channel.sv */
// Self-checking testbench for the fault and sync control channel.
`timescale 1ns/10ps
`default_nettype none
module test_pfs_channel;
    import pfs_pkg::*;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    pfs_cfg_t cfg = '0;
    logic [FLT_W-1:0] pin = '0;
    logic [FLT_W-1:0] clr = '0;
    logic [NUM_CH-1:0][COMP_W-1:0] comp = {16'h0004, 16'h0003, 16'h0002, 16'h0001};
    logic [NUM_CH-1:0] mtrig = '0;
    logic go = 1'b0;
    logic sync_in, pwm_a, pwm_b, sync_out, sync_oe, irq, trig;
    logic [15:0] nt;
    logic [7:0] seen;
    logic [15:0] na, nb;
    pfs_stat_t stat;
    int mismatches = 0;
    int n_compared = 0;

    // The clock toggles every 12.5 ns, half of its 25 ns period.
    always #12.5 i_clk_sys = ~i_clk_sys;

    pfs_channel #(.CH_IDX(2'h0)) dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cfg(cfg),
        .i_fault_pin(pin), .i_fault_clr(clr), .i_comp_val(comp), .i_master_trig(mtrig),
        .i_sync_in(sync_in), .o_pwm_a(pwm_a), .o_pwm_b(pwm_b), .o_phase_trig(trig),
        .o_sync_out(sync_out), .o_sync_oe(sync_oe), .o_fault_irq(irq), .o_stat(stat));

    pfs_far_model far (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_go(go), .i_pin_out(sync_out),
        .i_pin_oe(sync_oe), .o_sync(sync_in), .o_seen(seen));

    // ----------------------------------------
    // Helper tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // Counts high cycles of A and B over one eight-cycle period.
    task automatic tally();
        na = '0;
        nb = '0;
        repeat (8) begin
            @(negedge i_clk_sys);
            na = na + {15'h0, pwm_a};
            nb = nb + {15'h0, pwm_b};
        end
    endtask

    // Waits, with a bound, for the period counter to show a value.
    task automatic wait_cnt(input logic [15:0] v);
        int k;
        k = 0;
        @(negedge i_clk_sys);
        while (stat.count !== v && k < 40) begin
            @(negedge i_clk_sys);
            k++;
        end
    endtask

    // Pulses one fault pin, checks blanking, clears it and checks the restart point.
    task automatic fault_run(input pfs_mode_t m, input logic en, input int f,
                             input logic [15:0] ea, input logic [15:0] eb);
        int k;
        @(posedge i_clk_sys);
        cfg.mode <= m;
        cfg.fault_en <= en;
        pin[f] <= 1'b1;
        @(posedge i_clk_sys);
        pin[f] <= 1'b0;
        @(negedge i_clk_sys);
        chk(stat.fault_latched, 16'h0001 << f);
        chk(stat.fault_pin_level, 16'h0001 << f);
        chk(irq, 1'b1);
        tally();
        chk(na, ea);
        chk(nb, eb);
        chk(stat.fault_latched, 16'h0001 << f);
        chk(stat.blank_a, 16'(ea == 16'h0000));
        chk(stat.blank_b, 16'(eb == 16'h0000));
        wait_cnt(16'h0003);
        @(posedge i_clk_sys);
        clr[f] <= 1'b1;
        @(posedge i_clk_sys);
        clr[f] <= 1'b0;
        @(negedge i_clk_sys);
        k = 0;
        while (stat.count !== 16'h0000 && k < 16) begin
            if (ea == 16'h0000) chk(pwm_a, 1'b0);
            if (eb == 16'h0000) chk(pwm_b, 1'b0);
            @(negedge i_clk_sys);
            k++;
        end
        chk(pwm_a, 1'b1);
        chk(stat.fault_latched, 16'h0000);
        chk(stat.blank_a, 16'h0000);
        chk(irq, 1'b0);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        cfg.period = 16'h0007;
        repeat (4) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        // Each selector value routes its own compensator duty.
        for (int s = 0; s < 4; s++) begin
            @(posedge i_clk_sys);
            cfg.comp_sel <= s[1:0];
            repeat (8) @(posedge i_clk_sys);
            tally();
            chk(na, 16'(s + 1));
        end
        @(posedge i_clk_sys);
        cfg.mode <= PFS_MODE_RESON;
        repeat (8) @(posedge i_clk_sys);
        tally();
        chk(na, 16'h0001);
        cfg.comp_sel <= 2'h0;
        $display("test compensator routing done");
        fault_run(PFS_MODE_NORMAL, 1'b1, 0, 16'h0000, 16'h0000);
        fault_run(PFS_MODE_NORMAL, 1'b1, 1, 16'h0000, 16'h0000);
        fault_run(PFS_MODE_MULTI, 1'b1, 0, 16'h0000, 16'h0007);
        fault_run(PFS_MODE_PHASE, 1'b1, 1, 16'h0001, 16'h0000);
        fault_run(PFS_MODE_RESON, 1'b1, 0, 16'h0000, 16'h0007);
        fault_run(PFS_MODE_NORMAL, 1'b0, 0, 16'h0001, 16'h0007);
        $display("test fault shutdown done");
        @(posedge i_clk_sys);
        cfg.isync_en <= 1'b1;
        cfg.isync_sel <= 2'h2;
        wait_cnt(16'h0003);
        @(posedge i_clk_sys);
        mtrig <= 4'h4;
        @(posedge i_clk_sys);
        mtrig <= 4'h2;
        @(negedge i_clk_sys);
        chk(stat.count, 16'h0000);
        @(posedge i_clk_sys);
        mtrig <= 4'h0;
        @(negedge i_clk_sys);
        chk(stat.count, 16'h0001);
        @(posedge i_clk_sys);
        cfg.isync_en <= 1'b0;
        cfg.rsync_en <= 1'b1;
        wait_cnt(16'h0003);
        @(posedge i_clk_sys);
        go <= 1'b1;
        @(posedge i_clk_sys);
        go <= 1'b0;
        @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk(stat.count, 16'h0000);
        $display("test counter sync done");
        @(posedge i_clk_sys);
        cfg.rsync_en <= 1'b0;
        cfg.sync_div <= 4'h1;
        cfg.sync_out_src <= 1'b1;
        @(negedge i_clk_sys);
        na = {8'h00, seen};
        nb = '0;
        nt = '0;
        repeat (32) begin
            if (sync_out === 1'b1) begin
                nb = nb + 16'h0001;
                chk(stat.count, 16'h0000);
            end
            if (trig === 1'b1) begin
                nt = nt + 16'h0001;
                chk(stat.count, 16'h0000);
            end
            @(negedge i_clk_sys);
        end
        chk(nb, 16'h0002);
        chk(nt, 16'h0004);
        chk({8'h00, seen} - na, 16'h0002);
        chk(sync_oe, 1'b1);
        @(posedge i_clk_sys);
        cfg.sync_out_src <= 1'b0;
        @(negedge i_clk_sys);
        chk(sync_oe, 1'b0);
        $display("test sync output done");
        // A reset in mid-run clears the latch and restarts the counter from zero.
        @(posedge i_clk_sys);
        pin <= 2'h1;
        @(posedge i_clk_sys);
        pin <= 2'h0;
        i_rst_n <= 1'b0;
        @(negedge i_clk_sys);
        chk(irq, 1'b0);
        chk(stat.count, 16'h0000);
        chk(sync_out, 1'b0);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(negedge i_clk_sys);
        chk(stat.count, 16'h0000);
        @(negedge i_clk_sys);
        chk(stat.count, 16'h0001);
        chk(stat.fault_latched, 16'h0000);
        $display("test mid-run reset done");
        final_report();
    end

    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge i_clk_sys);
        mismatches++;
        final_report();
    end
endmodule
`default_nettype wire
